// *** core/thi_defs.vh ***
// constants for the transceiver host interrupt block
`ifndef THI_DEFS_VH
`define THI_DEFS_VH
`define THI_CNT_W 5
`define THI_LVL_EMPTY 5'h00
`define THI_LVL_4 5'h04
`define THI_LVL_8 5'h08
`define THI_LVL_12 5'h0C
`define THI_SEL_EMPTY 2'h0
`define THI_SEL_4 2'h1
`define THI_SEL_8 2'h2
`define THI_SEL_12 2'h3
`endif

// *** core/thi_sync.v ***
// two flip-flop synchroniser, one instance per bit
`timescale 1ns/10ps
module thi_sync #(
  parameter WIDTH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      reg stage1_ff;
      reg stage2_ff;
      always @(posedge ref_clk) begin
        if (rst) begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
        end else if (clkEn) begin
          stage1_ff <= asyncIn[i];
          stage2_ff <= stage1_ff;
        end
      end
      assign syncOut[i] = stage2_ff;
    end
  endgenerate
endmodule

// *** core/thi_irq_ctrl.v ***
// interrupt request logic facing the host microcontroller
`timescale 1ns/10ps
`include "thi_defs.vh"
module thi_irq_ctrl (
  input wire ref_clk,
  input wire rst,
  input wire clkEn,
  input wire stateStatusBit,
  input wire powerOnFlag,
  input wire auxPowerOnFlag,
  input wire serialInTxDirect,
  input wire fillThresholdSelLo,
  input wire fillThresholdSelHi,
  input wire transparentMode,
  input wire patternMode,
  input wire txMode,
  input wire rxMode,
  input wire [`THI_CNT_W-1:0] txCount,
  input wire [`THI_CNT_W-1:0] rxCount,
  input wire rxError,
  input wire bitCheckOk,
  input wire statusRead,
  input wire deleteIrqCmd,
  input wire txBufWrite,
  input wire bufRead,
  input wire ctrlRegWrite,
  output wire irq,
  output reg txDirectData_ff,
  output wire bufferEnable,
  output wire manchesterEnable,
  output reg statusPending_ff,
  output reg txPending_ff,
  output reg rxPending_ff
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // status flags and the direct tx pin come from other domains
  wire [3:0] syncIn;
  thi_sync #(.WIDTH(4)) uSync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clkEn(clkEn),
    .asyncIn({serialInTxDirect, auxPowerOnFlag, powerOnFlag, stateStatusBit}),
    .syncOut(syncIn)
  );

  // ---------------------------------------------------------------
  // edge history
  // ---------------------------------------------------------------
  // history resets low, so a pin already high at release reads as an event
  reg stPrev_ff;
  reg ponPrev_ff;
  reg auxPrev_ff;
  reg [`THI_CNT_W-1:0] txPrev_ff;
  reg [`THI_CNT_W-1:0] rxPrev_ff;
  reg errPrev_ff;
  reg bitPrev_ff;

  always @(posedge ref_clk) begin
    if (rst) begin
      stPrev_ff <= 1'b0;
      ponPrev_ff <= 1'b0;
      auxPrev_ff <= 1'b0;
      txPrev_ff <= `THI_LVL_EMPTY;
      rxPrev_ff <= `THI_LVL_EMPTY;
      errPrev_ff <= 1'b0;
      bitPrev_ff <= 1'b0;
    end else if (clkEn) begin
      stPrev_ff <= syncIn[0];
      ponPrev_ff <= syncIn[1];
      auxPrev_ff <= syncIn[2];
      txPrev_ff <= txCount;
      rxPrev_ff <= rxCount;
      errPrev_ff <= rxError;
      bitPrev_ff <= bitCheckOk;
    end
  end

  // ---------------------------------------------------------------
  // event detection
  // ---------------------------------------------------------------
  wire [1:0] thrSel = {fillThresholdSelHi, fillThresholdSelLo};
  reg [`THI_CNT_W-1:0] txLevel;
  reg [`THI_CNT_W-1:0] rxLevel;
  always @* begin
    case (thrSel)
      `THI_SEL_EMPTY: txLevel = `THI_LVL_EMPTY;
      `THI_SEL_4: txLevel = `THI_LVL_4;
      `THI_SEL_8: txLevel = `THI_LVL_8;
      `THI_SEL_12: txLevel = `THI_LVL_12;
      default: txLevel = `THI_LVL_EMPTY;
    endcase
    // empty has no rx meaning; that code only leaves the error and bit check sources
    case (thrSel)
      `THI_SEL_4: rxLevel = `THI_LVL_4;
      `THI_SEL_8: rxLevel = `THI_LVL_8;
      `THI_SEL_12: rxLevel = `THI_LVL_12;
      default: rxLevel = `THI_LVL_EMPTY;
    endcase
  end
  // status bit toggles both ways; power flags only on their rise
  wire stToggle = (syncIn[0] != stPrev_ff);
  wire ponRise = syncIn[1] & ~ponPrev_ff;
  wire auxRise = syncIn[2] & ~auxPrev_ff;
  wire statusEvt = stToggle | ponRise | auxRise;

  // a level reached while filling must not fire, only while draining
  wire txDown = (txCount < txPrev_ff);
  wire txLvlHit = (txCount == txLevel);
  wire txBuffered = txMode & ~transparentMode;
  wire txEvt = txBuffered & txDown & txLvlHit;

  wire rxLvlHit = (rxLevel != `THI_LVL_EMPTY) & (rxCount == rxLevel) & (rxPrev_ff != rxLevel);
  wire rxErrEvt = rxError & ~errPrev_ff;
  // buffer reads mask byte and error sources, not the bit check
  wire rxDataEvt = (rxLvlHit | rxErrEvt) & ~bufRead;
  wire bitEvt = ~patternMode & bitCheckOk & ~bitPrev_ff;
  wire rxBuffered = rxMode & ~transparentMode;
  wire rxEvt = rxBuffered & (rxDataEvt | bitEvt);

  // ---------------------------------------------------------------
  // source latch next state
  // ---------------------------------------------------------------
  // set wins over clear so an event in the clear cycle is never lost
  reg statusClr;
  reg txClr;
  reg rxClr;
  reg nxt_statusPending;
  reg nxt_txPending;
  reg nxt_rxPending;

  always @* begin
    statusClr = statusRead | deleteIrqCmd;
    txClr = txBufWrite | ctrlRegWrite | deleteIrqCmd;
    rxClr = ctrlRegWrite | deleteIrqCmd;
    nxt_statusPending = statusPending_ff;
    if (statusClr) begin
      nxt_statusPending = 1'b0;
    end
    if (statusEvt) begin
      nxt_statusPending = 1'b1;
    end
    nxt_txPending = txPending_ff;
    if (txClr) begin
      nxt_txPending = 1'b0;
    end
    if (txEvt) begin
      nxt_txPending = 1'b1;
    end
    nxt_rxPending = rxPending_ff;
    if (rxClr) begin
      nxt_rxPending = 1'b0;
    end
    if (rxEvt) begin
      nxt_rxPending = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // source latches
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      statusPending_ff <= 1'b0;
      txPending_ff <= 1'b0;
      rxPending_ff <= 1'b0;
    end else if (clkEn) begin
      statusPending_ff <= nxt_statusPending;
      txPending_ff <= nxt_txPending;
      rxPending_ff <= nxt_rxPending;
    end
  end

  // ---------------------------------------------------------------
  // transparent tx data
  // ---------------------------------------------------------------
  // transparent tx bit follows the pin; zero while buffered
  always @(posedge ref_clk) begin
    if (rst) begin
      txDirectData_ff <= 1'b0;
    end else if (clkEn) begin
      txDirectData_ff <= transparentMode & syncIn[3];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign irq = statusPending_ff | txPending_ff | rxPending_ff;
  assign bufferEnable = ~transparentMode;
  assign manchesterEnable = ~patternMode;
endmodule

// *** tb/thi_irq_ctrl_sva.sv ***
// port assertions for the interrupt block
`timescale 1ns/10ps
module thi_irq_ctrl_sva (input wire ref_clk, rst, statusRead, deleteIrqCmd, txBufWrite, ctrlRegWrite, irq,
  transparentMode, patternMode, bufferEnable, manchesterEnable, statusPending_ff, txPending_ff, rxPending_ff);
  wire cmdClr = deleteIrqCmd | ctrlRegWrite;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_txUp; !txPending_ff ##1 txPending_ff; endsequence
  sequence s_stDn; statusPending_ff ##1 !statusPending_ff; endsequence
  property p_or; irq == (statusPending_ff | txPending_ff | rxPending_ff); endproperty
  a_or: assert property (p_or) else $error("irq not or");
  property p_hold; irq && !(cmdClr | statusRead | txBufWrite) |=> irq; endproperty
  a_hold: assert property (p_hold) else $error("irq lost");
  property p_st; s_stDn |-> $past(statusRead | deleteIrqCmd); endproperty
  a_st: assert property (p_st) else $error("bad clear");
  property p_tx; txPending_ff ##1 !txPending_ff |-> $past(txBufWrite | cmdClr); endproperty
  a_tx: assert property (p_tx) else $error("bad clear");
  property p_rx; rxPending_ff ##1 !rxPending_ff |-> $past(cmdClr); endproperty
  a_rx: assert property (p_rx) else $error("bad clear");
  property p_tm; s_txUp |-> $past(!transparentMode); endproperty
  a_tm: assert property (p_tm) else $error("tx level");
  property p_buf; bufferEnable == !transparentMode; endproperty
  a_buf: assert property (p_buf) else $error("buffer");
  property p_man; manchesterEnable == !patternMode; endproperty
  a_man: assert property (p_man) else $error("coder");
endmodule
bind thi_irq_ctrl thi_irq_ctrl_sva thi_irq_ctrl_sva_i (.*);

// *** tb/thi_host_model.sv ***
// host model: reads status, then services the buffer
`timescale 1ns/10ps
module thi_host_model (input wire ref_clk, hostEn, irq, output reg statusRead = 0, txBufWrite = 0);
  reg [1:0] step_ff = 0;
  always @(negedge ref_clk) begin
    statusRead <= hostEn && irq && !step_ff;
    txBufWrite <= step_ff[1] && irq;
    step_ff <= {step_ff[0], hostEn && irq && !step_ff};
  end
endmodule

// *** tb/thi_irq_ctrl_bench.sv ***
// bench for the host interrupt block
`timescale 1ns/10ps
module thi_irq_ctrl_bench;
  bit ref_clk, rst = 1, clkEn = 1, serialInTxDirect, hostEn, stateStatusBit, powerOnFlag, auxPowerOnFlag;
  bit deleteIrqCmd, ctrlRegWrite, fillThresholdSelLo, fillThresholdSelHi, transparentMode, patternMode;
  bit bufRead, txMode, rxMode, rxError, bitCheckOk;
  bit [4:0] txCount, rxCount;
  wire statusRead, txBufWrite, irq, txDirectData_ff, bufferEnable, manchesterEnable;
  wire statusPending_ff, txPending_ff, rxPending_ff;
  logic [15:0] rows [13] = '{16'h1002, 16'h1242, 16'h1482, 16'h16C2, 16'h1280, 16'h9240, 16'h0A41,
    16'h0C81, 16'h0EC1, 16'h0809, 16'h2808, 16'h0805, 16'h4804};
  logic [2:0] stSteps [4] = '{3'h1, 3'h0, 3'h2, 3'h6};
  int num_errors = 0, checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  thi_irq_ctrl thi_irq_ctrl_i (.*);
  thi_host_model thi_host_model_i (.*);
  task check(input logic ok);
    checks_done++;
    num_errors += !ok;
    if (!ok) $display("wrong value at %0t: irq state", $time);
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait, host may clear it
  task wait_irq(input logic lvl);
    for (int n = 0; n < 9 && irq !== lvl; n++) @(negedge ref_clk);
    check(irq === lvl);
    if (irq !== lvl) stop_test;
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 0;
    check({irq, statusPending_ff, txPending_ff, rxPending_ff} === 4'h0);
    foreach (rows[i]) begin
      {transparentMode, patternMode, bufRead, txMode, rxMode, fillThresholdSelHi, fillThresholdSelLo} = rows[i][15:9];
      {txCount, rxCount, deleteIrqCmd, ctrlRegWrite} = {rows[i][8:4] + 5'h01, 7'h00};
      @(negedge ref_clk);
      {txCount, rxError, bitCheckOk} = rows[i][8:2];
      rxCount = txCount;
      repeat (2) @(negedge ref_clk);
      check({txPending_ff, rxPending_ff, irq} === {rows[i][1:0], |rows[i][1:0]});
      {bufRead, txMode, rxMode, rxError, bitCheckOk, deleteIrqCmd, ctrlRegWrite} = {5'h00, i[0], !i[0]};
      @(negedge ref_clk);
      check(irq === 1'b0);
    end
    {hostEn, deleteIrqCmd, ctrlRegWrite} = 3'h4;
    foreach (stSteps[k]) begin
      {auxPowerOnFlag, powerOnFlag, stateStatusBit} = stSteps[k];
      wait_irq(1'b1);
      wait_irq(1'b0);
    end
    {txMode, fillThresholdSelHi, fillThresholdSelLo, txCount} = 8'hA5;
    @(negedge ref_clk);
    txCount = 5'h04;
    wait_irq(1'b1);
    wait_irq(1'b0);
    // transparent path, then a frozen clock enable holds it
    {transparentMode, serialInTxDirect} = 2'h3;
    repeat (4) @(negedge ref_clk);
    check({txDirectData_ff, bufferEnable, manchesterEnable} === 3'h4);
    {clkEn, serialInTxDirect} = 2'h0;
    repeat (4) @(negedge ref_clk);
    check(txDirectData_ff === 1'b1);
    clkEn = 1;
    repeat (4) @(negedge ref_clk);
    check(txDirectData_ff === 1'b0);
    {transparentMode, patternMode, hostEn, stateStatusBit} = 4'h1;
    wait_irq(1'b1);
    // mid-run reset drops the latch; pins still high give a fresh event
    rst = 1;
    repeat (2) @(negedge ref_clk);
    check({irq, bufferEnable, manchesterEnable} === 3'h3);
    rst = 0;
    wait_irq(1'b1);
    deleteIrqCmd = 1;
    @(negedge ref_clk);
    deleteIrqCmd = 0;
    check(irq === 1'b0);
    stop_test;
  end
endmodule
